// >>> dv/aspr_host.sv
// host serial master model: clock idles low, drives on rise, samples on fall
`timescale 1ns/1ps
module aspr_host (
	output logic       cs_n,
	output logic       sclk,
	output logic       din,
	input  wire logic  miso,
	output logic [7:0] rx,
	output logic       rx_stb
);
	initial cs_n = 1'b1;
	initial sclk = 1'b0;
	initial din = 1'b0;
	initial rx = 8'h00;
	initial rx_stb = 1'b0;
	// one byte msb first at a 48 ns link period
	task automatic xfer(input logic [7:0] tx);
		logic [7:0] r;
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b1;
			din = tx[i];
			#24;
			sclk = 1'b0;
			r[i] = miso;
			#24;
		end
		din = ~din; // idle data keeps moving so a stale level cannot pass
		rx = r;
		rx_stb = 1'b1;
		#1;
		rx_stb = 1'b0;
	endtask : xfer
	// whole frame under one chip select
	task automatic frame(input logic [7:0] b [$]);
		cs_n = 1'b0;
		#60;
		foreach (b[i]) xfer(b[i]);
		#60;
		cs_n = 1'b1;
		#60;
	endtask : frame
	// select the device without clocking, so the pin shows the ready level
	task automatic select;
		cs_n = 1'b0;
	endtask : select
	// a stray rising edge, then silence longer than the timeout
	task automatic glitch;
		cs_n = 1'b0;
		#60;
		sclk = 1'b1;
		#24;
		sclk = 1'b0;
		#600;
	endtask : glitch
endmodule : aspr_host

// >>> dv/aspr_port_sva.sv
// pin and ready timing assertions for the converter serial port
`timescale 1ns/1ps
module aspr_port_sva (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic pulse_mode,
	input wire logic conv_start,
	input wire logic conv_stop,
	input wire logic conv_near_done,
	input wire logic conv_done,
	input wire logic shared_out_ready_pin_oe_n,
	input wire logic conversion_ready_n,
	input wire logic crc_error_flag,
	input wire logic cmd_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// windows of four cycles leave room for the two-flop chip select sync
	a_float_desel: assert property (cs_n [*4] |-> shared_out_ready_pin_oe_n) else $error("pin driven");
	a_drive_sel: assert property (!cs_n [*4] |-> !shared_out_ready_pin_oe_n) else $error("pin floats");
	a_start_high: assert property (conv_start |-> ##[1:3] conversion_ready_n) else $error("no start");
	a_pulse_low: assert property (pulse_mode && conv_done |-> ##[1:3] !conversion_ready_n) else $error("no ready");
	a_pulse_hold: assert property (pulse_mode && $rose(conversion_ready_n) |-> $past(conv_start, 1)
		|| $past(conv_start, 2) || $past(conv_start, 3) || $past(conv_stop, 1) || $past(conv_stop, 2)
		|| $past(conv_stop, 3)) else $error("ready rose");
	a_early_pulse: assert property (!pulse_mode && conv_near_done && cs_n |-> ##[0:3] conversion_ready_n)
		else $error("no early pulse");
	a_err_sticky: assert property (cs_n [*4] ##0 crc_error_flag |=> crc_error_flag) else $error("err lost");
	a_desel_quiet: assert property (cs_n [*6] |-> !cmd_valid) else $error("command while deselected");
endmodule : aspr_port_sva
bind aspr_port aspr_port_sva aspr_port_sva_inst (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n),
	.pulse_mode(pulse_mode), .conv_start(conv_start), .conv_stop(conv_stop), .conv_near_done(conv_near_done),
	.conv_done(conv_done),
	.shared_out_ready_pin_oe_n(shared_out_ready_pin_oe_n), .conversion_ready_n(conversion_ready_n),
	.crc_error_flag(crc_error_flag), .cmd_valid(cmd_valid));

// >>> dv/tb_aspr_port.sv
// self-checking bench for the converter serial port
`timescale 1ns/1ps
module tb_aspr_port;
	import aspr_pkg::*;
	logic               clk_sys = 1'b0, rstn = 1'b0, conv_start = 1'b0, conv_done = 1'b0, conv_near_done = 1'b0;
	logic               tmo_en = 1'b0, stat_en = 1'b0, crc_en = 1'b0, pulse_mode = 1'b0;
	logic signed [25:0] conv_raw = 26'sh0000000;
	logic [7:0]         status_other = 8'h00, rx, cb1, cb2, exp_q [$];
	logic               cs_n, sclk, din, pin, oe_n, rdy_n, err, cmd_valid, rx_stb;
	wire                miso;
	int                 bad_count = 0, checks_done = 0, n_cmd = 0;
	assign miso = oe_n ? ~pin : pin; // a released pin reads inverted, so sampling it while floating mismatches
	always #2.5 clk_sys = ~clk_sys;
	aspr_port #(.TIMEOUT(100)) aspr_port_inst (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .din(din),
		.shared_out_ready_pin(pin), .shared_out_ready_pin_oe_n(oe_n), .conversion_ready_n(rdy_n),
		.serial_timeout_enable(tmo_en), .status_byte_enable(stat_en), .crc_check_enable(crc_en),
		.pulse_mode(pulse_mode), .conv_start(conv_start), .conv_stop(1'b0), .conv_near_done(conv_near_done),
		.conv_done(conv_done), .conv_raw(conv_raw), .status_other(status_other), .crc_error_flag(err),
		.cmd_valid(cmd_valid), .cmd_byte1(cb1), .cmd_byte2(cb2));
	aspr_host aspr_host_inst (.cs_n(cs_n), .sclk(sclk), .din(din), .miso(miso), .rx(rx), .rx_stb(rx_stb));
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		checks_done++;
		if (got !== want) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	function automatic logic [7:0] crc8(input logic [7:0] b [$]);
		logic [7:0] c;
		c = 8'hff;
		foreach (b[i]) for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	function automatic logic [23:0] sat(input logic signed [25:0] v);
		if (v > 26'sh07fffff) return 24'h7fffff;
		if (v < -26'sh0800000) return 24'h800000;
		return v[23:0];
	endfunction : sat
	task automatic pulse(ref logic s);
		@(negedge clk_sys) s = 1'b1;
		@(negedge clk_sys) s = 1'b0;
	endtask : pulse
	// bounded wait for the ready level, then compare it
	task automatic settle(input logic want);
		for (int n = 0; n < 20 && rdy_n !== want; n++) @(negedge clk_sys);
		chk({7'h00, rdy_n}, {7'h00, want});
	endtask : settle
	// oldest expectation is taken off the queue as each byte lands
	always @(posedge rx_stb) chk(rx, exp_q.pop_front());
	always @(posedge clk_sys) if (cmd_valid === 1'b1) n_cmd++;
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
	initial begin
		logic signed [25:0] v [3];
		logic [23:0] e;
		logic [7:0] a, c, s;
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		void'($urandom(34));
		chk({7'h00, rdy_n}, 8'h01);
		chk({6'h00, err, oe_n}, 8'h01);
		v[0] = 26'($signed(24'($urandom)));
		v[1] = 26'sh1000000;
		v[2] = 26'sh3000000;
		for (int i = 0; i < 3; i++) begin
			conv_raw = v[i];
			pulse(conv_start);
			settle(1'b1);
			pulse(conv_done);
			settle(1'b0);
			aspr_host_inst.select();
			repeat (4) @(negedge clk_sys);
			chk({6'h00, pin, oe_n}, 8'h00);
			a = 8'($urandom);
			e = sat(v[i]);
			exp_q = {exp_q, 8'hff, 8'h12, e[23:16], e[15:8], e[7:0]};
			aspr_host_inst.frame('{8'h12, a, 8'h00, 8'h00, 8'h00});
			settle(1'b1);
		end
		pulse(conv_done);
		pulse(conv_near_done);
		settle(1'b1);
		pulse(conv_done);
		settle(1'b0);
		s = 8'($urandom);
		status_other = s;
		stat_en = 1'b1;
		crc_en = 1'b1;
		c = crc8('{8'h12, a});
		s = {s[7], 2'b10, s[4:0]};
		exp_q = {exp_q, 8'hff, 8'h12, a, c, s, e[23:16], e[15:8], e[7:0], crc8('{s, e[23:16], e[15:8], e[7:0]})};
		aspr_host_inst.frame('{8'h12, a, c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		chk(8'(n_cmd), 8'h04);
		chk(cb1, 8'h12);
		chk(cb2, a);
		c = crc8('{8'h00, a});
		exp_q = {exp_q, 8'hff, 8'h00, a, ~c};
		aspr_host_inst.frame('{8'h00, a, ~c, 8'h00});
		chk({6'h00, err, n_cmd == 4}, 8'h03);
		c = crc8('{8'h21, a});
		s = {s[7], 2'b01, s[4:0]};
		exp_q = {exp_q, 8'hff, 8'h21, a, c, s, crc8('{s})};
		aspr_host_inst.frame('{8'h21, a, c, 8'h00, 8'h00, 8'h00});
		@(negedge clk_sys);
		chk({7'h00, err}, 8'h00);
		stat_en = 1'b0;
		crc_en = 1'b0;
		tmo_en = 1'b1;
		aspr_host_inst.glitch();
		exp_q = {exp_q, 8'hff, 8'h12, e[23:16], e[15:8], e[7:0]};
		aspr_host_inst.frame('{8'h12, a, 8'h00, 8'h00, 8'h00});
		@(negedge clk_sys);
		// a result lands while a read begun in the late window is answering:
		// the old result goes out and ready falls only when the read ends
		conv_raw = v[0];
		pulse(conv_near_done);
		exp_q = {exp_q, 8'hff, 8'h12, e[23:16], e[15:8], e[7:0]};
		fork
			aspr_host_inst.frame('{8'h12, a, 8'h00, 8'h00, 8'h00});
			begin
				repeat (250) @(negedge clk_sys);
				pulse(conv_done);
				chk({7'h00, rdy_n}, 8'h01);
			end
		join
		settle(1'b0);
		e = sat(v[0]);
		pulse_mode = 1'b1;
		tmo_en = 1'b0;
		pulse(conv_start);
		settle(1'b1);
		pulse(conv_done);
		settle(1'b0);
		exp_q = {exp_q, 8'hff, 8'h12, e[23:16], e[15:8], e[7:0]};
		aspr_host_inst.frame('{8'h12, a, 8'h00, 8'h00, 8'h00});
		chk({7'h00, rdy_n}, 8'h00);
		chk(8'(exp_q.size()), 8'h00);
		test_done();
	end
endmodule : tb_aspr_port

// >>> include/aspr_pkg.sv
// constants and types for the converter serial port with ready and crc
package aspr_pkg;
	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned TIMEOUT_CYC      = 65536;   // master clock cycles
	localparam int unsigned LATE_WIN_CYC     = 16;      // master clock cycles before ready edge
	localparam logic [7:0]  CRC_POLY         = 8'h07;   // x^8+x^2+x+1, top bit implicit
	localparam logic [7:0]  CRC_PRESET       = 8'hff;
	localparam logic [7:0]  FIRST_BYTE_OUT   = 8'hff;
	localparam logic [23:0] CODE_POS_FS      = 24'h7fffff;
	localparam logic [23:0] CODE_NEG_FS      = 24'h800000;
	localparam logic [7:0]  CMD_READ_DATA    = 8'h12;
	localparam logic [7:0]  CMD_STATUS_READ  = 8'h21;   // register read, status register address
	localparam logic [2:0]  CMD_READ_MASK    = 3'h1;    // top three opcode bits of a register read
	localparam int unsigned STAT_READY_BIT   = 6;
	localparam int unsigned STAT_CRC_ERROR_FLAG_BIT  = 5;
	typedef enum logic [1:0] {
		ASPR_IDLE_type_s = 2'b00,
		ASPR_CMD_s       = 2'b01,
		ASPR_RESP_s      = 2'b10,
		ASPR_DONE_s      = 2'b11
	} aspr_state_type;
endpackage : aspr_pkg

// >>> logic/aspr_port.sv
// serial host port: shared out/ready pin, auto-reset, ready timing, status, crc
`timescale 1ns/1ps
// What this block does
// - shared pin shifts data during a read, reverts to ready indication afterwards
// - output bits change on serial clock rising edges; host samples on falling
// - in ready mode shared pin mirrors ready output when selected, floats otherwise
// - chip select high returns serial logic to its initial state
// - first rising edge starts timer; byte must finish in 65536 clocks
// - byte finished in time does not reset; supervision restarts next rising edge
// - serial clock low for 65536 clocks resets interface
// - auto-reset gated by enable bit, disabled after reset
// - continuous mode: ready high at start, low when new data arrive
// - continuous mode: ready high at read end; unread data pulse ready high 16 clocks early
// - late read returns old data; ready low deferred to read end, status clear
// - late read with new data: ready falls on time, status bit set
// - pulse mode: ready high at start, low when ready, stays low through reads
// - status ready bit set when data new since previous read
// - response is optional status, three data bytes, optional crc over both
// - status byte prepended only when status enable set; status readable directly
// - results 24-bit two's complement, sign bit first
// - out-of-range results saturate at full scale codes
// - crc mode: two bytes, crc, zero byte; match executes and returns crc
// - successful crc read appends crc over returned payload
// - mismatch skips command, returns inverted crc, sets crc error flag
// - crc polynomial x^8+x^2+x+1, preset all ones
// - second byte slot echoes first command byte; third slot echoes second command byte in crc mode only
// - serial mode with clock idling low, phase one
// - chip select high ignores serial clock; ready output keeps running
module aspr_port #(
	parameter int unsigned TIMEOUT = aspr_pkg::TIMEOUT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        din,
	output logic             shared_out_ready_pin,
	output logic             shared_out_ready_pin_oe_n,
	output logic             conversion_ready_n,
	input  wire logic        serial_timeout_enable,
	input  wire logic        status_byte_enable,
	input  wire logic        crc_check_enable,
	input  wire logic        pulse_mode,
	input  wire logic        conv_start,
	input  wire logic        conv_stop,
	input  wire logic        conv_near_done,
	input  wire logic        conv_done,
	input  wire logic signed [25:0] conv_raw,
	input  wire logic [7:0]  status_other,
	output logic             crc_error_flag,
	output logic             cmd_valid,
	output logic [7:0]       cmd_byte1,
	output logic [7:0]       cmd_byte2
);
	import aspr_pkg::*;

	// largest timeout that the 17-bit supervision timers can count
	localparam int unsigned TMO_MAX = 131072;

	// refuse a timeout that the timers cannot count or that would fire at once
	if (TIMEOUT < 2 || TIMEOUT > TMO_MAX) begin : g_bad_timeout
		$error("timeout out of range");
	end

	// crc step over one byte, msb first; the same step serves commands, status and data,
	// so host and device can never disagree on bit order
	function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
			r = (r[7] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		return r;
	endfunction : crc_byte

	// saturate a wide result to 24 bits; clipping instead of wrapping keeps an overdriven
	// input from reading as the opposite full scale
	function automatic logic [23:0] sat24(input logic signed [25:0] v);
		if (v > $signed({2'b00, CODE_POS_FS}))
			return CODE_POS_FS;
		else if (v < $signed({2'b11, CODE_NEG_FS}))
			return CODE_NEG_FS;
		return v[23:0];
	endfunction : sat24

	// two-flop synchronisers for pins
	logic [1:0] cs_s_q, sclk_s_q, din_s_q;
	logic       sclk_d1_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cs_s_q    <= 2'b11;
			sclk_s_q  <= 2'b00;
			din_s_q   <= 2'b00;
			sclk_d1_q <= 1'b0;
		end else begin
			cs_s_q    <= {cs_s_q[0], cs_n};
			sclk_s_q  <= {sclk_s_q[0], sclk};
			din_s_q   <= {din_s_q[0], din};
			sclk_d1_q <= sclk_s_q[1];
		end
	end

	// edges are found one clock after the second flop, so a serial edge is seen 2-3 clocks late;
	// that delay is why the serial clock must stay well below a quarter of the system clock
	wire cs_hi   = cs_s_q[1];
	wire sck_rise = !cs_hi && sclk_s_q[1] && !sclk_d1_q;
	wire sck_fall = !cs_hi && !sclk_s_q[1] && sclk_d1_q;

	// timeout supervision: one timer runs from the first rising edge of a byte to its end,
	// another counts how long the serial clock has been low; both only act when enabled,
	// so a slow host is never cut off unless it asked for the protection
	logic [16:0] tmo_q;
	logic        tmo_run_q;
	logic [16:0] low_q;
	logic [3:0]  bit_q;
	wire byte_tmo  = serial_timeout_enable && tmo_run_q && (tmo_q >= 17'(TIMEOUT - 1));
	wire low_reset = serial_timeout_enable && (low_q >= 17'(TIMEOUT - 1));
	wire if_reset  = cs_hi || byte_tmo || low_reset;
	wire byte_end  = sck_fall && (bit_q == 4'h7);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tmo_q     <= 17'h00000;
			tmo_run_q <= 1'b0;
			low_q     <= 17'h00000;
		end else begin
			low_q <= (sclk_s_q[1] || low_reset) ? 17'h00000 : low_q + 17'h00001;
			if (if_reset || byte_end) begin
				tmo_run_q <= 1'b0;
				tmo_q     <= 17'h00000;
			end else if (sck_rise && !tmo_run_q) begin
				tmo_run_q <= 1'b1;
				tmo_q     <= 17'h00000;
			end else if (tmo_run_q)
				tmo_q <= tmo_q + 17'h00001;
		end
	end

	// conversion ready and data holding
	// a result that lands while a late read is answering is parked in the converter's own
	// output and picked up when the read ends; the ready level falls only then, so the host
	// is never told about data that it has not been offered yet
	logic [23:0] data_q;
	logic        new_q, ready_n_q, defer_q, late_q;
	aspr_state_type st_q;
	logic        is_data_q;
	wire reading = (st_q == ASPR_RESP_s) && is_data_q;
	wire read_done;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			data_q    <= 24'h000000;
			new_q     <= 1'b0;
			ready_n_q <= 1'b1;
			defer_q   <= 1'b0;
			late_q    <= 1'b0;
		end else begin
			if (conv_near_done && !pulse_mode)
				late_q <= 1'b1;
			if (conv_start || conv_stop) begin
				ready_n_q <= 1'b1;
				late_q    <= 1'b0;
			end else if (conv_done) begin
				late_q <= 1'b0;
				if (reading && late_q) begin
					defer_q <= 1'b1;
					new_q   <= 1'b1;
				end else begin
					data_q    <= sat24(conv_raw);
					new_q     <= 1'b1;
					ready_n_q <= 1'b0;
				end
			end else if (conv_near_done && !pulse_mode && ready_n_q == 1'b0)
				ready_n_q <= 1'b1;
			else if (read_done) begin
				new_q <= defer_q;
				if (defer_q) begin
					data_q    <= sat24(conv_raw);
					ready_n_q <= 1'b0;
					defer_q   <= 1'b0;
				end else if (!pulse_mode)
					ready_n_q <= 1'b1;
			end
		end
	end
	assign conversion_ready_n = ready_n_q;

	// status byte: the converter's own bits with the ready and crc error positions replaced;
	// the ready bit stays clear while a late read is being answered with the old result
	logic [7:0] status_w;
	always_comb begin
		status_w                  = status_other;
		status_w[STAT_READY_BIT]  = new_q && !defer_q;
		status_w[STAT_CRC_ERROR_FLAG_BIT] = crc_error_flag;
	end

	// command receive and response shift
	// bytes are assembled on falling edges; the byte to send next is loaded on the falling
	// edge that ends the previous one, so its first bit stands before the host's next sample
	// and later bits move on rising edges
	logic [7:0]  sh_in_q, b1_q, b2_q, b3_q, out_q, crc_q;
	logic [2:0]  byte_q;
	logic [39:0] resp_q;
	logic [2:0]  resp_left_q;
	logic        crc_error_flag_q, bad_q;
	wire  [2:0]  cmd_len   = crc_check_enable ? 3'h4 : 3'h2;
	wire  [7:0]  rx_byte   = {sh_in_q[6:0], din_s_q[1]};
	wire         cmd_last  = byte_end && (st_q == ASPR_CMD_s) && (byte_q == cmd_len - 3'h1);
	wire         crc_ok    = crc_byte(crc_byte(CRC_PRESET, b1_q), b2_q) == b3_q;
	wire         exec      = cmd_last && (!crc_check_enable || crc_ok);
	wire         is_rdata  = b1_q == CMD_READ_DATA;
	wire         is_status = b1_q == CMD_STATUS_READ;
	wire  [7:0]  cmd_crc   = crc_byte(crc_byte(CRC_PRESET, b1_q), b2_q);
	wire  [7:0]  crc_s     = crc_byte(CRC_PRESET, status_w);
	wire  [7:0]  crc_d     = crc_byte(crc_byte(crc_byte(status_byte_enable ? crc_s : CRC_PRESET,
		data_q[23:16]), data_q[15:8]), data_q[7:0]);
	// a response ends on the falling edge that completes its last byte
	wire         go_resp   = exec && (is_rdata || is_status);
	wire         resp_end  = (st_q == ASPR_RESP_s) && byte_end && (resp_left_q == 3'h1);
	wire         crc_match = cmd_crc == rx_byte;
	assign read_done = reading && (resp_end || if_reset);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= ASPR_CMD_s; sh_in_q <= 8'h00; bit_q <= 4'h0; byte_q <= 3'h0;
			b1_q <= 8'h00; b2_q <= 8'h00; b3_q <= 8'h00; out_q <= FIRST_BYTE_OUT;
			resp_q <= 40'h0; resp_left_q <= 3'h0; crc_error_flag_q <= 1'b0; is_data_q <= 1'b0;
		end else begin
			if (st_q == ASPR_RESP_s && is_status && byte_end && !cs_hi)
				crc_error_flag_q <= 1'b0;                        // cleared by a status read
			if (cmd_last && crc_check_enable && !crc_ok)
				crc_error_flag_q <= 1'b1;                        // set wins over clear
			// deselection or a timeout drops any partial byte and command
			if (if_reset) begin
				st_q <= ASPR_CMD_s; bit_q <= 4'h0; byte_q <= 3'h0;
				out_q <= FIRST_BYTE_OUT; is_data_q <= 1'b0;
			end else if (sck_rise && bit_q != 4'h0)
				out_q <= {out_q[6:0], 1'b1};            // shift on rising edge
			else if (sck_fall) begin
				sh_in_q <= rx_byte;
				bit_q   <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
				if (byte_end) begin
					case (st_q)
						ASPR_CMD_s: begin
							byte_q <= byte_q + 3'h1;
							if (byte_q == 3'h0) begin b1_q <= rx_byte; out_q <= rx_byte; end
							if (byte_q == 3'h1) begin b2_q <= rx_byte; out_q <= rx_byte; end
							// the fourth slot answers with the crc of the bytes received,
							// inverted when it disagrees with the crc the host sent
							if (byte_q == 3'h2) begin
								b3_q  <= rx_byte;
								out_q <= crc_match ? cmd_crc : ~cmd_crc;
							end
						end
						ASPR_RESP_s: resp_left_q <= resp_left_q - 3'h1;
						default: ;
					endcase
					if (cmd_last) begin
						byte_q <= 3'h0;
						if (exec && (is_rdata || is_status)) begin
							st_q      <= ASPR_RESP_s;
							is_data_q <= is_rdata;
							if (is_rdata) begin
								resp_q <= status_byte_enable ? {status_w, data_q, crc_d}
									: {data_q, crc_d, 8'hff};
								resp_left_q <= 3'((status_byte_enable ? 4 : 3) + (crc_check_enable ? 1 : 0));
							end else begin
								resp_q      <= {status_w, crc_s, 24'hffffff};
								resp_left_q <= crc_check_enable ? 3'h2 : 3'h1;
							end
						end
					end else if (st_q == ASPR_RESP_s)
						resp_q <= {resp_q[31:0], 8'hff};
				end
			end else if (st_q == ASPR_RESP_s && bit_q == 4'h0 && !sck_rise)
				out_q <= resp_q[39:32];                  // msb first
			if (resp_end && !if_reset)
				st_q <= ASPR_CMD_s;
		end
	end

	// flag and the last command's bytes straight from their registers
	assign crc_error_flag = crc_error_flag_q;
	assign cmd_valid = exec;
	assign cmd_byte1 = b1_q;
	assign cmd_byte2 = b2_q;

	// the pin carries shift data from the first serial clock edge of a frame until the command,
	// or the response that it asks for, is over; at all other times it repeats the ready level.
	// tying this to the frame rather than to the response alone lets the host see the idle byte
	// and the echoes that precede the answer
	logic busy_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			busy_q <= 1'b0;
		else if (if_reset || resp_end || (cmd_last && !go_resp))
			busy_q <= 1'b0;
		else if (sck_rise)
			busy_q <= 1'b1;
	end

	// pin drive follows the synchronised chip select, so it floats a few clocks after deselection
	assign shared_out_ready_pin      = busy_q ? out_q[7] : ready_n_q;
	assign shared_out_ready_pin_oe_n = cs_hi;
endmodule : aspr_port
